// ### verilog/sfr_pkg.sv
// Purpose: shared constants and types for the dual-cpu status flag block
// Assumes: two cpus, 8-bit status bytes, one system clock
// Notes:   bit positions, offsets and reset values are defined here; the monitor also writes some as literals

package sfr_pkg;

  // data and machine widths
  localparam int SFR_W    = 8;
  localparam int SFR_NCPU = 2;
  localparam int SFR_AW   = 4;

  // status byte bit positions
  localparam int SFR_BIT_C = 0;
  localparam int SFR_BIT_Z = 1;
  localparam int SFR_BIT_I = 2;
  localparam int SFR_BIT_D = 3;
  localparam int SFR_BIT_B = 4;
  localparam int SFR_BIT_U = 5;
  localparam int SFR_BIT_V = 6;
  localparam int SFR_BIT_N = 7;

  // reset value: irq disable set, decimal clear, the rest held at zero
  localparam logic [7:0] SFR_STATUS_RST = 8'h04;

  // register offsets on the software port
  localparam logic [3:0] SFR_OFF_STATUS_A = 4'h0;
  localparam logic [3:0] SFR_OFF_STATUS_B = 4'h1;
  localparam logic [3:0] SFR_OFF_BUSY     = 4'h2;

  // timing: clock period and the extra cycle of decimal arithmetic
  localparam int SFR_CLK_NS    = 10;
  localparam int SFR_DEC_EXTRA = 1;

  // flag operations a cpu core can request
  typedef enum logic [4:0] {
    SFR_OP_NONE      = 5'h00,
    SFR_OP_ADC       = 5'h01,
    SFR_OP_SBC       = 5'h02,
    SFR_OP_RESULT_NZ = 5'h03,
    SFR_OP_RESULT_NZC= 5'h04,
    SFR_OP_BIT       = 5'h05,
    SFR_OP_PULL      = 5'h06,
    SFR_OP_SET_C     = 5'h07,
    SFR_OP_CLR_C     = 5'h08,
    SFR_OP_SET_DEC   = 5'h09,
    SFR_OP_CLR_DEC   = 5'h0A,
    SFR_OP_SET_IRQD  = 5'h0B,
    SFR_OP_CLR_IRQD  = 5'h0C,
    SFR_OP_CLR_OVF   = 5'h0D,
    SFR_OP_ENTER_BRK = 5'h0E,
    SFR_OP_ENTER_IRQ = 5'h0F,
    SFR_OP_ENTER_NMI = 5'h10
  } sfr_op_e;

  // per-cpu sequencer states
  typedef enum logic [1:0] {
    SFR_ST_IDLE = 2'b00,
    SFR_ST_DEC  = 2'b01
  } sfr_state_e;

  // request from a cpu core
  typedef struct packed {
    logic       valid;
    sfr_op_e    op;
    logic [7:0] opnd_a;
    logic [7:0] opnd_b;
    logic [7:0] data;
  } sfr_req_s;

  // answer back to a cpu core
  typedef struct packed {
    logic       done;
    logic [7:0] result;
  } sfr_ans_s;

endpackage

// ### verilog/sfr_bin_adder.sv
// Purpose: 8-bit binary add or subtract with carry and signed overflow
// Assumes: subtract is a plus inverted b plus carry (carry = not borrow)
// Notes:   purely combinational

`timescale 1ns/1ps

module sfr_bin_adder (
  input  wire logic [7:0] a,    // accumulator operand
  input  wire logic [7:0] b,    // memory operand
  input  wire logic       cin,  // carry in
  input  wire logic       sub,  // high for subtract
  output logic      [7:0] sum,  // result byte
  output logic            cout, // carry out of bit 7
  output logic            ovf   // signed overflow
);

  logic [7:0] b_eff;
  logic [8:0] full;

  // subtract folds into add through one's complement
  always_comb begin
    b_eff = sub ? ~b : b;
    full  = {1'b0, a} + {1'b0, b_eff} + {8'h00, cin};
    sum   = full[7:0];
    cout  = full[8];
    // sign flips wrongly when both inputs agree and the result does not
    ovf   = (a[7] == b_eff[7]) && (full[7] != a[7]);
  end

endmodule

// ### verilog/sfr_dec_adjust.sv
// Purpose: packed bcd add and subtract on two digit pairs
// Assumes: operands are valid bcd; carry in means no borrow on subtract
// Notes:   combinational; the caller spends an extra cycle around it

`timescale 1ns/1ps

module sfr_dec_adjust (
  input  wire logic [7:0] a,    // accumulator operand
  input  wire logic [7:0] b,    // memory operand
  input  wire logic       cin,  // carry in
  input  wire logic       sub,  // high for subtract
  output logic      [7:0] sum,  // bcd result
  output logic            cout  // decimal carry, or not borrow
);

  logic [4:0] lo;
  logic [4:0] hi;
  logic       lo_c;
  logic       hi_c;

  // digit-wise correction by six on carry or borrow
  always_comb begin
    lo   = 5'h00;
    hi   = 5'h00;
    lo_c = 1'b0;
    hi_c = 1'b0;
    if (sub) begin
      lo   = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~cin};
      lo_c = lo[4];
      if (lo_c) begin
        lo = lo - 5'h06;
      end
      hi   = {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, lo_c};
      hi_c = hi[4];
      if (hi_c) begin
        hi = hi - 5'h06;
      end
      cout = ~hi_c;
    end else begin
      lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      lo_c = (lo > 5'h09);
      if (lo_c) begin
        lo = lo + 5'h06;
      end
      hi   = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo_c};
      hi_c = (hi > 5'h09);
      if (hi_c) begin
        hi = hi + 5'h06;
      end
      cout = hi_c;
    end
    sum = {hi[3:0], lo[3:0]};
  end

endmodule

// ### verilog/sfr_flag_regs.sv
// Purpose: two independent cpu status registers with their flag logic
// Assumes: each cpu core issues one flag request per instruction step
// Notes:   software port reads both status bytes and may overwrite them
//          a software write loses to a same-cycle instruction update
//
// Overview of operation
// - decimal flag selects bcd add and subtract
// - decimal add or subtract takes one extra cycle
// - only set, clear, pull change decimal flag; a software port write also changes it here
// - reset clears decimal flag on both cpus
// - break flag marks break versus irq entry
// - add and subtract set overflow on sign error
// - clear overflow touches only its own cpu
// - bit test copies bits 6, 7 into flags
// - overflow changed by five instruction kinds only
// - negative flag follows result bit 7
// - negative flag updated by result instructions, bit test and pull
// - status byte bit layout is fixed
// - reset sets irq disable, clears decimal
// - one independent status register per cpu
// - interrupt acceptance sets irq disable, masks irqs
// - irq disable set, cleared, or pulled by instructions
// - zero flag set when result all zero
// - carry flag follows carry out of bit 7

`timescale 1ns/1ps

module sfr_flag_regs (
  input  wire logic                      clk_sys,    // system clock, 100 MHz
  input  wire logic                      reset,      // synchronous, active high
  input  wire sfr_pkg::sfr_req_s [1:0]   req,        // flag request per cpu
  output sfr_pkg::sfr_ans_s      [1:0]   ans,        // result and done per cpu
  output logic                   [1:0][7:0] status,  // status byte per cpu
  output logic                   [1:0]   irq_enable, // maskable irq allowed
  output logic                   [1:0]   busy,       // decimal cycle running
  input  wire logic              [3:0]   reg_addr,   // register offset
  input  wire logic              [7:0]   reg_wdata,  // write data
  input  wire logic                      reg_wr,     // write strobe
  input  wire logic                      reg_rd,     // read strobe
  output logic                   [7:0]   reg_rdata   // read data, next cycle
);

  import sfr_pkg::*;

  // one generate index, one cpu per pass
  genvar g;

  // one copy of the whole flag machine per cpu, nothing shared
  generate
    for (g = 0; g < SFR_NCPU; g = g + 1) begin : cpu
      localparam logic [3:0] MY_OFF = (g == 0) ? SFR_OFF_STATUS_A : SFR_OFF_STATUS_B;

      // sequencer state of this cpu
      sfr_state_e state;
      sfr_state_e next_state;

      // next values worked out by the flag logic
      logic [7:0] next_flags;
      logic [7:0] next_result;
      logic       next_done;
      logic       instr_upd;

      // request decode and software hit
      logic       is_sub;
      logic       wr_hit;

      // binary adder outputs
      logic [7:0] bin_sum;
      logic       bin_cout;
      logic       bin_ovf;

      // decimal adjuster outputs
      logic [7:0] dec_sum;
      logic       dec_cout;

      // operands held for the bcd cycle, refreshed every idle cycle
      logic [7:0] lat_a;
      logic [7:0] lat_b;
      logic       lat_cin;
      logic       lat_sub;
      logic       lat_ovf;

      // subtract selects the inverted operand in the binary adder and the subtract path in the bcd one
      assign is_sub = (req[g].op == SFR_OP_SBC);
      // a write only hits the status byte of this cpu
      assign wr_hit = reg_wr && (reg_addr == MY_OFF);

      // binary path works straight off the request
      sfr_bin_adder u_bin (
        .a    (req[g].opnd_a),
        .b    (req[g].opnd_b),
        .cin  (status[g][SFR_BIT_C]),
        .sub  (is_sub),
        .sum  (bin_sum),
        .cout (bin_cout),
        .ovf  (bin_ovf)
      );

      // decimal path works off latched operands, hence the extra cycle
      sfr_dec_adjust u_dec (
        .a    (lat_a),
        .b    (lat_b),
        .cin  (lat_cin),
        .sub  (lat_sub),
        .sum  (dec_sum),
        .cout (dec_cout)
      );

      // next flags, result and sequencer step
      always_comb begin
        next_flags  = status[g];
        next_result = ans[g].result;
        next_done   = 1'b0;
        next_state  = state;
        instr_upd   = 1'b0;
        // idle takes requests, the decimal state finishes a bcd operation
        case (state)
          SFR_ST_IDLE: begin
            // a request counts only while idle; busy refuses it
            if (req[g].valid) begin
              instr_upd = 1'b1;
              next_done = 1'b1;
              case (req[g].op)
                // carry in is the current carry flag
                SFR_OP_ADC, SFR_OP_SBC: begin
                  if (status[g][SFR_BIT_D]) begin
                    // hold the answer back one cycle for bcd correction
                    next_done  = 1'b0;
                    next_state = SFR_ST_DEC;
                  end else begin
                    // binary result lands at once
                    next_result             = bin_sum;
                    next_flags[SFR_BIT_N]   = bin_sum[7];
                    next_flags[SFR_BIT_Z]   = (bin_sum == 8'h00);
                    next_flags[SFR_BIT_C]   = bin_cout;
                    next_flags[SFR_BIT_V]   = bin_ovf;
                  end
                end
                // loads, logic ops and moves hand in their result
                SFR_OP_RESULT_NZ: begin
                  next_result           = req[g].data;
                  next_flags[SFR_BIT_N] = req[g].data[7];
                  next_flags[SFR_BIT_Z] = (req[g].data == 8'h00);
                end
                SFR_OP_RESULT_NZC: begin
                  // shifts and compares hand in their own carry out
                  next_result           = req[g].data;
                  next_flags[SFR_BIT_N] = req[g].data[7];
                  next_flags[SFR_BIT_Z] = (req[g].data == 8'h00);
                  next_flags[SFR_BIT_C] = req[g].opnd_b[0];
                end
                // memory bits 7 and 6 land in n and v, z from the and
                SFR_OP_BIT: begin
                  next_flags[SFR_BIT_N] = req[g].data[7];
                  next_flags[SFR_BIT_V] = req[g].data[6];
                  next_flags[SFR_BIT_Z] = ((req[g].opnd_a & req[g].data) == 8'h00);
                end
                SFR_OP_PULL: begin
                  // break bit is not loaded by a pull, so it keeps its stored value
                  next_flags[SFR_BIT_N] = req[g].data[SFR_BIT_N];
                  next_flags[SFR_BIT_V] = req[g].data[SFR_BIT_V];
                  next_flags[SFR_BIT_D] = req[g].data[SFR_BIT_D];
                  next_flags[SFR_BIT_I] = req[g].data[SFR_BIT_I];
                  next_flags[SFR_BIT_Z] = req[g].data[SFR_BIT_Z];
                  next_flags[SFR_BIT_C] = req[g].data[SFR_BIT_C];
                end
                // carry control by program
                SFR_OP_SET_C: begin
                  next_flags[SFR_BIT_C] = 1'b1;
                end
                // clear carry before a fresh add
                SFR_OP_CLR_C: begin
                  next_flags[SFR_BIT_C] = 1'b0;
                end
                // decimal mode only moves on program request
                SFR_OP_SET_DEC: begin
                  next_flags[SFR_BIT_D] = 1'b1;
                end
                // back to binary arithmetic
                SFR_OP_CLR_DEC: begin
                  next_flags[SFR_BIT_D] = 1'b0;
                end
                // mask maskable requests
                SFR_OP_SET_IRQD: begin
                  next_flags[SFR_BIT_I] = 1'b1;
                end
                // let maskable requests through
                SFR_OP_CLR_IRQD: begin
                  next_flags[SFR_BIT_I] = 1'b0;
                end
                // own cpu only, the other copy never sees it
                SFR_OP_CLR_OVF: begin
                  next_flags[SFR_BIT_V] = 1'b0;
                end
                // software break marks its entry and masks irqs
                SFR_OP_ENTER_BRK: begin
                  next_flags[SFR_BIT_B] = 1'b1;
                  next_flags[SFR_BIT_I] = 1'b1;
                end
                SFR_OP_ENTER_IRQ: begin
                  // a masked request is ignored and answered with no change
                  if (!status[g][SFR_BIT_I]) begin
                    next_flags[SFR_BIT_B] = 1'b0;
                    next_flags[SFR_BIT_I] = 1'b1;
                  end
                end
                // non-maskable entry ignores the mask but still sets it
                SFR_OP_ENTER_NMI: begin
                  next_flags[SFR_BIT_B] = 1'b0;
                  next_flags[SFR_BIT_I] = 1'b1;
                end
                // unknown codes are dropped with no answer
                default: begin
                  instr_upd = 1'b0;
                  next_done = 1'b0;
                end
              endcase
            end
          end
          SFR_ST_DEC: begin
            // overflow keeps its binary meaning even in decimal mode
            instr_upd             = 1'b1;
            next_done             = 1'b1;
            next_result           = dec_sum;
            next_flags[SFR_BIT_N] = dec_sum[7];
            next_flags[SFR_BIT_Z] = (dec_sum == 8'h00);
            next_flags[SFR_BIT_C] = dec_cout;
            next_flags[SFR_BIT_V] = lat_ovf;
            next_state            = SFR_ST_IDLE;
          end
          default: begin
            next_state = SFR_ST_IDLE;
          end
        endcase
        // software overwrite loses to a same-cycle instruction update
        if (wr_hit && !instr_upd) begin
          next_flags = reg_wdata;
        end
        // bit 5 has no storage and always reads zero
        next_flags[SFR_BIT_U] = 1'b0;
      end

      // sequencer and decimal operand latch
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          state   <= SFR_ST_IDLE;
          busy[g] <= 1'b0;
          lat_a   <= 8'h00;
          lat_b   <= 8'h00;
          lat_cin <= 1'b0;
          lat_sub <= 1'b0;
          lat_ovf <= 1'b0;
        end else begin
          state   <= next_state;
          busy[g] <= (next_state == SFR_ST_DEC);
          // sampling every idle cycle saves a separate load enable
          if (state == SFR_ST_IDLE) begin
            lat_a   <= req[g].opnd_a;
            lat_b   <= req[g].opnd_b;
            lat_cin <= status[g][SFR_BIT_C];
            lat_sub <= is_sub;
            lat_ovf <= bin_ovf;
          end
        end
      end

      // status byte and the irq gate derived from it
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          status[g]     <= SFR_STATUS_RST;
          irq_enable[g] <= 1'b0;
        end else begin
          // irq gate taken from the next value so it never lags the byte
          status[g]     <= next_flags;
          irq_enable[g] <= ~next_flags[SFR_BIT_I];
        end
      end

      // answer to the core, done is a one-cycle pulse
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          ans[g] <= '0;
        end else begin
          ans[g].done   <= next_done;
          ans[g].result <= next_result;
        end
      end
    end
  endgenerate

  // software read port, data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      // unmapped offsets read as zero
      case (reg_addr)
        SFR_OFF_STATUS_A: reg_rdata <= status[0];
        SFR_OFF_STATUS_B: reg_rdata <= status[1];
        SFR_OFF_BUSY:     reg_rdata <= {6'h00, busy};
        default:          reg_rdata <= 8'h00;
      endcase
    end else begin
      // drop back to zero so stale data never reads as fresh
      reg_rdata <= 8'h00;
    end
  end

endmodule

// ### dv/sfr_flag_regs_monitor.sv
// Purpose: port-level checker for the dual-cpu status flag block
// Assumes: one clock domain, synchronous active-high reset
// Notes:   cpu a carries the timing checks; cpu b is covered by the bench

`timescale 1ns/1ps

module sfr_flag_regs_monitor (
  input wire logic                    clk_sys,    // system clock
  input wire logic                    reset,      // sync reset
  input wire sfr_pkg::sfr_req_s [1:0] req,        // flag requests
  input wire sfr_pkg::sfr_ans_s [1:0] ans,        // answers
  input wire logic         [1:0][7:0] status,     // status bytes
  input wire logic              [1:0] irq_enable, // irq allowed
  input wire logic              [1:0] busy,       // decimal cycle
  input wire logic              [3:0] reg_addr,   // register offset
  input wire logic              [7:0] reg_wdata,  // write data
  input wire logic                    reg_wr,     // write strobe
  input wire logic                    reg_rd,     // read strobe
  input wire logic              [7:0] reg_rdata   // read data
);
  import sfr_pkg::*;

  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (reset);

  // request of cpu a taken this edge; busy refuses new work
  logic tk0;
  logic ar0;
  assign tk0 = req[0].valid && !busy[0];
  assign ar0 = tk0 && (req[0].op == SFR_OP_ADC || req[0].op == SFR_OP_SBC);

  property p_rst; $fell(reset) |-> status[0] == 8'h04 && status[1] == 8'h04; endproperty
  a_rst: assert property (p_rst) else $error("reset status wrong");
  property p_u5; !status[0][SFR_BIT_U] && !status[1][SFR_BIT_U]; endproperty
  a_u5: assert property (p_u5) else $error("unused bit set");
  property p_ien; irq_enable == ~{status[1][SFR_BIT_I], status[0][SFR_BIT_I]}; endproperty
  a_ien: assert property (p_ien) else $error("irq enable mismatch");
  // decimal arithmetic costs one extra cycle
  property p_dec; ar0 && status[0][SFR_BIT_D] |=> busy[0] && !ans[0].done ##1 ans[0].done;
  endproperty
  a_dec: assert property (p_dec) else $error("decimal timing wrong");
  property p_bin; ar0 && !status[0][SFR_BIT_D] |=> ans[0].done && !busy[0]; endproperty
  a_bin: assert property (p_bin) else $error("binary timing wrong");
  property p_sd; tk0 && req[0].op == SFR_OP_SET_DEC |=> status[0][SFR_BIT_D]; endproperty
  a_sd: assert property (p_sd) else $error("decimal not set");
  property p_cd; tk0 && req[0].op == SFR_OP_CLR_DEC |=> !status[0][SFR_BIT_D]; endproperty
  a_cd: assert property (p_cd) else $error("decimal not cleared");
  // decimal flag only moves when asked to
  property p_dh; !tk0 && !reg_wr |=> $stable(status[0][SFR_BIT_D]); endproperty
  a_dh: assert property (p_dh) else $error("decimal changed alone");
  property p_clv; tk0 && req[0].op == SFR_OP_CLR_OVF |=> !status[0][SFR_BIT_V]; endproperty
  a_clv: assert property (p_clv) else $error("overflow not cleared");
  property p_bit; tk0 && req[0].op == SFR_OP_BIT |=> status[0][7:6] == $past(req[0].data[7:6]);
  endproperty
  a_bit: assert property (p_bit) else $error("bit test flags wrong");
  property p_vk; tk0 && req[0].op == SFR_OP_RESULT_NZ && !reg_wr |=> $stable(status[0][6]);
  endproperty
  a_vk: assert property (p_vk) else $error("overflow touched");
  property p_brk; tk0 && req[0].op == SFR_OP_ENTER_BRK |=> status[0][4] && status[0][2];
  endproperty
  a_brk: assert property (p_brk) else $error("break entry wrong");
  // break cleared and irq disable set, checked only for an unmasked request
  property p_irq; tk0 && req[0].op == SFR_OP_ENTER_IRQ && !status[0][2]
    |=> !status[0][4] && status[0][2]; endproperty
  a_irq: assert property (p_irq) else $error("irq entry wrong");
  property p_rd; reg_rd && reg_addr == SFR_OFF_STATUS_B && !req[1].valid && !busy[1]
    |=> reg_rdata == status[1]; endproperty
  a_rd: assert property (p_rd) else $error("status read wrong");
endmodule

bind sfr_flag_regs sfr_flag_regs_monitor mon (.clk_sys(clk_sys), .reset(reset), .req(req),
  .ans(ans), .status(status), .irq_enable(irq_enable), .busy(busy), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// ### dv/sfr_flag_regs_tb.sv
// Purpose: directed bench for the dual-cpu status flag block
// Assumes: requests one at a time per cpu, answers awaited under a bound
// Notes:   expected status bytes are worked out by hand per step

`timescale 1ns/1ps

module sfr_flag_regs_tb;
  import sfr_pkg::*;
  logic            clk_sys     = 1'b0;
  logic            reset       = 1'b1;
  sfr_req_s  [1:0] req         = '0;
  sfr_ans_s  [1:0] ans;
  logic [1:0][7:0] status;
  logic      [1:0] irq_enable;
  logic      [1:0] busy;
  logic      [3:0] reg_addr    = 4'h0;
  logic      [7:0] reg_wdata   = 8'h00;
  logic            reg_wr      = 1'b0;
  logic            reg_rd      = 1'b0;
  logic      [7:0] res;
  logic      [7:0] nc;
  logic      [7:0] bz;
  logic      [7:0] reg_rdata;
  int              miscompares = 0;
  int              compares    = 0;
  int              cyc         = 0;

  sfr_flag_regs uut (.clk_sys(clk_sys), .reset(reset), .req(req), .ans(ans), .status(status),
    .irq_enable(irq_enable), .busy(busy), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  always #5 clk_sys = ~clk_sys;

  // hang guard, far above the hundred or so cycles needed
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask

  // one flag request, then wait for done and compare the status byte
  task automatic run(input int c, input sfr_op_e o, input logic [7:0] es,
                     input logic [7:0] a = 8'h00, input logic [7:0] b = 8'h00,
                     input logic [7:0] d = 8'h00);
    int n;
    n = 0;
    @(posedge clk_sys);
    req[c] <= {1'b1, o, a, b, d};
    @(posedge clk_sys);
    req[c].valid <= 1'b0;
    #1;
    bz = {7'h00, busy[c]};
    while (ans[c].done !== 1'b1 && n < 8) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    res = ans[c].result;
    nc = 8'(n + 1);
    chk("status", es, status[c]);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic test_done();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // main sequence: arithmetic, modes, entries, software port, reset again
  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    chk("status_a", 8'h04, status[0]);
    chk("status_b", 8'h04, status[1]);
    chk("irq_en", 8'h00, {6'h00, irq_enable});
    rd(SFR_OFF_STATUS_A, res);
    chk("rd_a", 8'h04, res);
    run(0, SFR_OP_CLR_C, 8'h04);
    run(0, SFR_OP_ADC, 8'hC4, 8'h50, 8'h50);
    chk("sum", 8'hA0, res);
    run(0, SFR_OP_SET_C, 8'hC5);
    run(0, SFR_OP_ADC, 8'h07, 8'hFF, 8'h00);
    chk("sum", 8'h00, res);
    run(0, SFR_OP_SBC, 8'h45, 8'h80, 8'h01);
    chk("diff", 8'h7F, res);
    chk("bin_cyc", 8'h01, nc);
    chk("bin_busy", 8'h00, bz);
    run(0, SFR_OP_SET_DEC, 8'h4D);
    chk("status_b", 8'h04, status[1]);
    run(0, SFR_OP_CLR_C, 8'h4C);
    run(0, SFR_OP_ADC, 8'h0C, 8'h19, 8'h28);
    chk("bcd_sum", 8'h47, res);
    chk("dec_cyc", 8'h02, nc);
    chk("dec_busy", 8'h01, bz);
    run(0, SFR_OP_SET_C, 8'h0D);
    run(0, SFR_OP_SBC, 8'h0D, 8'h50, 8'h01);
    chk("bcd_diff", 8'h49, res);
    run(0, SFR_OP_CLR_DEC, 8'h05);
    run(0, SFR_OP_CLR_C, 8'h04);
    run(0, SFR_OP_ADC, 8'h04, 8'h09, 8'h01);
    chk("bin_sum", 8'h0A, res);
    run(0, SFR_OP_BIT, 8'hC6, 8'h00, 8'h00, 8'hC0);
    run(0, SFR_OP_RESULT_NZ, 8'h44, 8'h00, 8'h00, 8'h01);
    fork
      run(0, SFR_OP_CLR_OVF, 8'h04);
      run(1, SFR_OP_BIT, 8'hC4, 8'hFF, 8'h00, 8'hC0);
    join
    run(0, SFR_OP_RESULT_NZ, 8'h06);
    run(0, SFR_OP_RESULT_NZC, 8'h85, 8'h00, 8'h01, 8'h80);
    run(0, SFR_OP_CLR_C, 8'h84);
    run(0, SFR_OP_CLR_IRQD, 8'h80);
    chk("irq_en", 8'h01, {6'h00, irq_enable});
    run(0, SFR_OP_ENTER_IRQ, 8'h84);
    chk("irq_en", 8'h00, {6'h00, irq_enable});
    run(0, SFR_OP_ENTER_BRK, 8'h94);
    run(0, SFR_OP_ENTER_IRQ, 8'h94);
    run(0, SFR_OP_CLR_IRQD, 8'h90);
    run(0, SFR_OP_ENTER_NMI, 8'h84);
    run(0, SFR_OP_SET_IRQD, 8'h84);
    run(0, SFR_OP_PULL, 8'hCF, 8'h00, 8'h00, 8'hFF);
    run(0, SFR_OP_PULL, 8'h00);
    // an unknown code changes nothing and is never answered
    run(0, SFR_OP_NONE, 8'h00);
    chk("none_cyc", 8'h09, nc);
    wr(SFR_OFF_STATUS_B, 8'hFF);
    chk("status_b", 8'hDF, status[1]);
    rd(SFR_OFF_STATUS_B, res);
    chk("rd_b", 8'hDF, res);
    wr(4'hF, 8'hAA);
    rd(4'hF, res);
    chk("rd_unmapped", 8'h00, res);
    rd(SFR_OFF_BUSY, res);
    chk("rd_busy", 8'h00, res);
    rd(SFR_OFF_STATUS_A, res);
    chk("rd_a", 8'h00, res);
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    chk("status_a", 8'h04, status[0]);
    chk("status_b", 8'h04, status[1]);
    test_done();
  end
endmodule
